// *** common/ivec_defs.svh ***
`ifndef IVEC_DEFS_SVH
`define IVEC_DEFS_SVH

// Word offsets on the Wishbone bus (byte addresses)
`define IVEC_OFS_CTRL 8'h00
`define IVEC_OFS_IRQ_STATUS 8'h04
`define IVEC_OFS_IRQ_MASK 8'h08

// Control register fields
`define IVEC_BIT_ALT_TABLE 15
`define IVEC_BIT_DISABLE_ACTIVE 14
`define IVEC_BIT_EDGE_POL0 0
`define IVEC_CTRL_WRITABLE 16'h8007
`define IVEC_CTRL_RESET 16'h0000

// Interrupt status and mask fields
`define IVEC_BIT_EV_EXT0 0
`define IVEC_BIT_EV_DISABLE_END 3
`define IVEC_EV_WIDTH 4
`define IVEC_EV_RESET 4'h0

// Vector table bases, word addresses of entry zero
`define IVEC_STD_TABLE_BASE 24'h000004
`define IVEC_ALT_TABLE_BASE 24'h000104

`define IVEC_EXT_COUNT 3
`define IVEC_DISABLE_CNT_W 14
`define IVEC_DISABLE_CNT_ZERO 14'h0000

`endif

// *** common/ivec_edge_if.sv ***
interface ivec_edge_if;
  import ivec_pkg::*;
  ivec_ext_t polarity;
  ivec_ext_t edgePulse;
  modport ctrl (output polarity, input edgePulse);
  modport detect (input polarity, output edgePulse);
endinterface : ivec_edge_if

// *** common/ivec_pkg.sv ***
package ivec_pkg;
  `include "ivec_defs.svh"

  typedef logic [15:0] ivec_word_t;
  typedef logic [`IVEC_EXT_COUNT-1:0] ivec_ext_t;
  typedef logic [`IVEC_EV_WIDTH-1:0] ivec_ev_t;

  typedef enum logic [1:0] {
    IVEC_BUS_IDLE = 2'b01,
    IVEC_BUS_ACK = 2'b10
  } ivec_bus_e;

  typedef enum logic [3:0] {
    IVEC_REG_NONE = 4'b0001,
    IVEC_REG_CTRL = 4'b0010,
    IVEC_REG_STATUS = 4'b0100,
    IVEC_REG_MASK = 4'b1000
  } ivec_reg_e;
endpackage : ivec_pkg

// *** dv/interrupt_vector_edge_control_test.sv ***
module interrupt_vector_edge_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ivec_pkg::*;
  logic clk_sys = 1'h0, nrst = 1'h0, cs = 1'h0, we = 1'h0, dstart;
  logic ack, alt, act, irq;
  logic [3:0] sel = 4'h0, bsel = 4'hF;
  logic [7:0] adr = 8'h00, vidx;
  logic [13:0] dcyc;
  logic [23:0] vaddr;
  logic [31:0] wdat = 32'h0, rdat, datO;
  ivec_ext_t pins, edg;
  int n_mismatch = 0, check_count = 0, n, cnt[3] = '{0, 0, 0};
  always #50 clk_sys = ~clk_sys;
  // An unknown pulse counts as an edge so that it cannot pass as zero
  always @(posedge clk_sys)
    for (int i = 0; i < 3; i++) cnt[i] += (edg[i] !== 1'h0);
  ivec_ctrl DUT (.clk_sys, .nrst, .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cs), .wb_stb_i(cs),
    .wb_dat_o(datO), .wb_ack_o(ack), .extIrqPin(pins),
    .timedDisableStart(dstart), .timedDisableCycles(dcyc),
    .vectorIndex(vidx), .vectorAddress(vaddr),
    .altVectorTableSelect(alt), .timedDisableActive(act),
    .extIrqEdge(edg), .irq);
  ivec_pin_model pm (.clk_sys, .extIrqPin(pins), .vectorIndex(vidx),
    .timedDisableStart(dstart), .timedDisableCycles(dcyc));
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  task end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clk_sys);
    cs <= 1'h1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= bsel;
    k = 0;
    do begin
      @(posedge clk_sys);
      k++;
    end while (ack !== 1'h1 && k < 20);
    rdat = datO;
    cs <= 1'h0;
    if (ack !== 1'h1) begin
      n_mismatch++;
      end_of_test;
    end
  endtask : bus
  task rd(logic [7:0] a, logic [31:0] e);
    bus(1'h0, a, 32'h0);
    chk("read", e, rdat);
  endtask : rd
  initial begin
    void'($urandom(5745));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'h1;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    // Unmapped place must swallow writes and read zero
    bus(1'h1, 8'h0C, 32'hFFFF);
    rd(8'h0C, 32'h0);
    bus(1'h1, 8'h08, 32'hF);
    rd(8'h08, 32'hF);
    for (int i = 0; i < 3; i++) for (int p = 0; p < 2; p++) begin
      n = p << i;
      bus(1'h1, 8'h00, n | 32'h4000);
      rd(8'h00, n);
      cnt[i] = 0;
      pm.pin(i, 1'h1);
      repeat (6) @(posedge clk_sys);
      chk("edge", !p, cnt[i]);
      chk("irq", !p, irq);
      pm.pin(i, 1'h0);
      repeat (6) @(posedge clk_sys);
      chk("edge", 1, cnt[i]);
      rd(8'h04, 1 << i);
      rd(8'h04, 32'h0);
    end
    for (int a = 0; a < 2; a++) begin
      n = $urandom % 256;
      bus(1'h1, 8'h00, a << 15);
      pm.vec(n);
      repeat (2) @(posedge clk_sys);
      chk("alt", a, alt);
      chk("vector", (a ? 32'h104 : 32'h4) + 2 * n, vaddr);
    end
    // Lane 1 disabled: bit 15 must keep its one
    bsel = 4'h1;
    bus(1'h1, 8'h00, 32'h0);
    bsel = 4'hF;
    rd(8'h00, 32'h8000);
    n = 20 + $urandom % 10;
    pm.start(n);
    repeat (2) @(posedge clk_sys);
    chk("active", 1, act);
    rd(8'h00, 32'hC000);
    repeat (n - 5) @(posedge clk_sys);
    chk("active", 1, act);
    @(posedge clk_sys);
    chk("active", 0, act);
    chk("irq", 1, irq);
    rd(8'h04, 32'h8);
    pm.start(0);
    repeat (2) @(posedge clk_sys);
    chk("active", 0, act);
    // Reset mid-run with pin 0 high: no false rising edge afterwards
    pm.pin(0, 1'h1);
    repeat (4) @(posedge clk_sys);
    nrst <= 1'h0;
    repeat (4) @(posedge clk_sys);
    nrst <= 1'h1;
    cnt[0] = 0;
    repeat (6) @(posedge clk_sys);
    chk("edge", 0, cnt[0]);
    chk("irq", 0, irq);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    end_of_test;
  end
endmodule : interrupt_vector_edge_control_test

// *** dv/ivec_ctrl_monitor.sv ***
module ivec_ctrl_monitor (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire ivec_pkg::ivec_ext_t extIrqPin,
  input wire logic timedDisableStart,
  input wire logic [13:0] timedDisableCycles,
  input wire logic [7:0] vectorIndex,
  input wire logic [23:0] vectorAddress,
  input wire logic altVectorTableSelect,
  input wire logic timedDisableActive,
  input wire ivec_pkg::ivec_ext_t extIrqEdge
);
  import ivec_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_vector_addr: assert property ($past(nrst) |-> vectorAddress ==
    ($past(altVectorTableSelect) ? 24'h000104 : 24'h000004)
    + {15'h0000, $past(vectorIndex), 1'h0}) else $error("bad vector");
  a_ctrl_read: assert property (wb_ack_o && !wb_we_i &&
    wb_adr_i == 8'h00 |-> (wb_dat_o & 32'hFFFF3FF8) == 32'h0 &&
    wb_dat_o[15:14] == $past({altVectorTableSelect, timedDisableActive}))
    else $error("bad control read");
  // Two sync flops plus the edge register give three cycles
  a_edge_cause: assert property (|extIrqEdge |-> (extIrqEdge &
    ~($past(extIrqPin, 3) ^ $past(extIrqPin, 4))) == 3'h0)
    else $error("edge without pin change");
  a_disable_start: assert property (timedDisableStart &&
    timedDisableCycles != 14'h0000 |=> timedDisableActive)
    else $error("disable did not start");
  a_disable_idle: assert property (!timedDisableActive &&
    !timedDisableStart |=> !timedDisableActive)
    else $error("disable without start");
  a_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("ack late");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_cause: assert property (wb_ack_o |-> wb_cyc_i && wb_stb_i)
    else $error("ack without request");
  cover property (|extIrqEdge);
  cover property ($fell(timedDisableActive));
  cover property ($rose(altVectorTableSelect));
endmodule : ivec_ctrl_monitor
bind ivec_ctrl ivec_ctrl_monitor mon (.clk_sys, .nrst, .wb_adr_i,
  .wb_we_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .extIrqPin,
  .timedDisableStart, .timedDisableCycles, .vectorIndex, .vectorAddress,
  .altVectorTableSelect, .timedDisableActive, .extIrqEdge);

// *** dv/ivec_pin_model.sv ***
module ivec_pin_model
  import ivec_pkg::*;
(
  input wire logic clk_sys,
  output ivec_pkg::ivec_ext_t extIrqPin,
  output logic timedDisableStart,
  output logic [13:0] timedDisableCycles,
  output logic [7:0] vectorIndex
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    extIrqPin = 3'h0;
    timedDisableStart = 1'h0;
    timedDisableCycles = 14'h0000;
    vectorIndex = 8'h00;
  end
  task pin(int i, logic v);
    @(posedge clk_sys);
    extIrqPin[i] <= v;
  endtask : pin
  task start(logic [13:0] n);
    @(posedge clk_sys);
    timedDisableStart <= 1'h1;
    timedDisableCycles <= n;
    @(posedge clk_sys);
    timedDisableStart <= 1'h0;
    // Length is only valid with the start pulse
    timedDisableCycles <= ~n;
  endtask : start
  task vec(logic [7:0] v);
    @(posedge clk_sys);
    vectorIndex <= v;
  endtask : vec
endmodule : ivec_pin_model

// *** logic/ivec_ctrl.sv ***
`include "ivec_defs.svh"

module ivec_ctrl
  import ivec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire ivec_pkg::ivec_ext_t extIrqPin,
  input wire logic timedDisableStart,
  input wire logic [13:0] timedDisableCycles,
  input wire logic [7:0] vectorIndex,
  output logic [23:0] vectorAddress,
  output logic altVectorTableSelect,
  output logic timedDisableActive,
  output ivec_pkg::ivec_ext_t extIrqEdge,
  output logic irq
);
  import ivec_pkg::*;

  ivec_bus_e busState;
  ivec_bus_e next_busState;
  ivec_reg_e regHit;
  logic request;
  logic writeNow;
  logic readNow;

  logic alternateVectorTableSelect;
  ivec_ext_t extIrqEdgePolarity;
  logic [`IVEC_DISABLE_CNT_W-1:0] disableCount;
  logic disableEnd;
  ivec_ev_t irqStatus;
  ivec_ev_t irqMask;
  ivec_ev_t events;
  ivec_ev_t readClear;
  ivec_word_t ctrlView;
  ivec_word_t ctrlMerged;

  ivec_edge_if edgeLink ();

  ivec_edge_detect edgeDetect (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .extIrqPin(extIrqPin),
    .edges(edgeLink.detect)
  );

  function automatic ivec_reg_e decodeReg(input logic [7:0] adr);
    if (adr == `IVEC_OFS_CTRL) begin
      decodeReg = IVEC_REG_CTRL;
    end else if (adr == `IVEC_OFS_IRQ_STATUS) begin
      decodeReg = IVEC_REG_STATUS;
    end else if (adr == `IVEC_OFS_IRQ_MASK) begin
      decodeReg = IVEC_REG_MASK;
    end else begin
      decodeReg = IVEC_REG_NONE;
    end
  endfunction : decodeReg

  // Byte-lane merge of a 16-bit register, used by the control register only
  function automatic ivec_word_t laneMerge(input ivec_word_t old,
                                           input logic [31:0] data,
                                           input logic [3:0] sel);
    laneMerge = old;
    if (sel[0]) begin
      laneMerge[7:0] = data[7:0];
    end
    if (sel[1]) begin
      laneMerge[15:8] = data[15:8];
    end
  endfunction : laneMerge

  assign regHit = decodeReg(wb_adr_i);
  assign request = wb_cyc_i & wb_stb_i;
  // Writes land on the edge where the master samples ack
  assign writeNow = request & wb_we_i & (busState == IVEC_BUS_ACK);
  assign readNow = request & ~wb_we_i & (busState == IVEC_BUS_ACK);

  // One wait state: ack decodes the registered busState, so each access takes two cycles
  always_comb begin
    next_busState = busState;
    case (busState)
      IVEC_BUS_IDLE: begin
        if (request) begin
          next_busState = IVEC_BUS_ACK;
        end
      end
      IVEC_BUS_ACK: begin
        next_busState = IVEC_BUS_IDLE;
      end
      default: begin
        next_busState = IVEC_BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      busState <= IVEC_BUS_IDLE;
    end else begin
      busState <= next_busState;
    end
  end

  assign wb_ack_o = (busState == IVEC_BUS_ACK) & request;

  always_comb begin
    ctrlView = `IVEC_CTRL_RESET;
    ctrlView[`IVEC_BIT_ALT_TABLE] = alternateVectorTableSelect;
    ctrlView[`IVEC_BIT_DISABLE_ACTIVE] = timedDisableActive;
    ctrlView[`IVEC_BIT_EDGE_POL0 +: `IVEC_EXT_COUNT] = extIrqEdgePolarity;
  end

  // Read data captured in the request cycle, stable through the ack cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wb_dat_o <= '0;
    end else if (request & (busState == IVEC_BUS_IDLE)) begin
      wb_dat_o <= '0;
      if (regHit == IVEC_REG_CTRL) begin
        wb_dat_o[15:0] <= ctrlView;
      end else if (regHit == IVEC_REG_STATUS) begin
        wb_dat_o[`IVEC_EV_WIDTH-1:0] <= irqStatus;
      end else if (regHit == IVEC_REG_MASK) begin
        wb_dat_o[`IVEC_EV_WIDTH-1:0] <= irqMask;
      end
    end
  end

  assign ctrlMerged = laneMerge(ctrlView, wb_dat_i, wb_sel_i);

  // Control register; bit 14 is not stored here and ignores writes
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      alternateVectorTableSelect <= 1'h0;
      extIrqEdgePolarity <= '0;
    end else if (writeNow && regHit == IVEC_REG_CTRL) begin
      alternateVectorTableSelect <= ctrlMerged[`IVEC_BIT_ALT_TABLE];
      extIrqEdgePolarity <=
        ctrlMerged[`IVEC_BIT_EDGE_POL0 +: `IVEC_EXT_COUNT];
    end
  end

  assign edgeLink.polarity = extIrqEdgePolarity;
  assign extIrqEdge = edgeLink.edgePulse;
  assign altVectorTableSelect = alternateVectorTableSelect;

  // Vector fetch address, registered so the CPU sees a clean word
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      vectorAddress <= `IVEC_STD_TABLE_BASE;
    end else begin
      vectorAddress <= (alternateVectorTableSelect ? `IVEC_ALT_TABLE_BASE
        : `IVEC_STD_TABLE_BASE) + {15'h0000, vectorIndex, 1'h0};
    end
  end

  // Timed disable: a fresh start reloads the count, even mid-period
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      disableCount <= `IVEC_DISABLE_CNT_ZERO;
    end else if (timedDisableStart) begin
      disableCount <= timedDisableCycles;
    end else if (disableCount != `IVEC_DISABLE_CNT_ZERO) begin
      disableCount <= disableCount - 14'h0001;
    end
  end

  assign timedDisableActive =
    (disableCount != `IVEC_DISABLE_CNT_ZERO);
  assign disableEnd = ~timedDisableStart
    & (disableCount == 14'h0001);

  always_comb begin
    events = `IVEC_EV_RESET;
    events[`IVEC_BIT_EV_EXT0 +: `IVEC_EXT_COUNT] = edgeLink.edgePulse;
    events[`IVEC_BIT_EV_DISABLE_END] = disableEnd;
  end

  // Only bits that were actually returned are cleared, and a new event
  // in the clearing cycle survives
  assign readClear = (readNow && regHit == IVEC_REG_STATUS)
    ? wb_dat_o[`IVEC_EV_WIDTH-1:0] : `IVEC_EV_RESET;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irqStatus <= `IVEC_EV_RESET;
    end else begin
      irqStatus <= (irqStatus & ~readClear) | events;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irqMask <= `IVEC_EV_RESET;
    end else if (writeNow && regHit == IVEC_REG_MASK && wb_sel_i[0]) begin
      irqMask <= wb_dat_i[`IVEC_EV_WIDTH-1:0];
    end
  end

  assign irq = |(irqStatus & irqMask);
endmodule : ivec_ctrl

// *** logic/ivec_edge_detect.sv ***
`include "ivec_defs.svh"

module ivec_edge_detect
  import ivec_pkg::*;
(
  input wire logic clk_sys,
  input wire logic nrst,
  input wire ivec_pkg::ivec_ext_t extIrqPin,
  ivec_edge_if.detect edges
);
  import ivec_pkg::*;

  ivec_ext_t syncFirst;
  ivec_ext_t syncSecond;
  ivec_ext_t pinPrev;
  ivec_ext_t next_edgePulse;
  logic firstValid;
  logic secondValid;
  logic prevValid;

  // Pins are asynchronous; only syncSecond feeds the edge logic
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      syncFirst <= '0;
      syncSecond <= '0;
      pinPrev <= '0;
    end else begin
      syncFirst <= extIrqPin;
      syncSecond <= syncFirst;
      pinPrev <= syncSecond;
    end
  end

  // Track which pipeline stages hold real pin history since reset
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      firstValid <= 1'h0;
      secondValid <= 1'h0;
      prevValid <= 1'h0;
    end else begin
      firstValid <= 1'h1;
      secondValid <= firstValid;
      prevValid <= secondValid;
    end
  end

  always_comb begin
    for (int i = 0; i < `IVEC_EXT_COUNT; i++) begin
      if (edges.polarity[i]) begin
        next_edgePulse[i] = pinPrev[i] & ~syncSecond[i];
      end else begin
        next_edgePulse[i] = syncSecond[i] & ~pinPrev[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      edges.edgePulse <= '0;
    end else if (!prevValid) begin
      // Reset zeros are not a pin level: a pin already high would look
      // like a rising edge. Limitation: edges in this window are lost.
      edges.edgePulse <= '0;
    end else begin
      edges.edgePulse <= next_edgePulse;
    end
  end
endmodule : ivec_edge_detect
